/* File: logic/cser_pkg.sv */
package cser_pkg;

  // ********************************
  // register offsets
  // ********************************
  localparam logic [7:0] OFS_PORT_DETECT = 8'h12;
  localparam logic [7:0] OFS_USB_PORT_TYPE = 8'h13;
  localparam logic [7:0] OFS_CONTACT_DETECT = 8'h14;
  localparam logic [7:0] OFS_SYS_RESET_CTRL = 8'h18;
  localparam logic [7:0] OFS_ADAPTER_REQ = 8'h19;
  localparam logic [7:0] OFS_IR_COMP_CTRL = 8'h1a;
  localparam logic [7:0] OFS_IDENT = 8'h40;
  localparam logic [7:0] OFS_CHARGER_STATE = 8'h42;
  localparam logic [7:0] OFS_THERM_ZONE = 8'h43;
  localparam logic [7:0] OFS_ADC_HIGH = 8'h44;
  localparam logic [7:0] OFS_ADC_LOW = 8'h45;
  localparam logic [7:0] OFS_LOOP_STATUS = 8'h50;
  localparam logic [7:0] OFS_PROTECT_STATUS = 8'h51;
  localparam logic [7:0] OFS_TEMP_STATUS = 8'h52;
  localparam logic [7:0] OFS_FAULT_EVENTS = 8'h53;
  localparam logic [7:0] OFS_CHARGE_EVENTS = 8'h54;
  localparam logic [7:0] OFS_BOOST_EVENTS = 8'h55;

  // ********************************
  // reset values and field positions
  // ********************************
  localparam logic [2:0] RST_USB_RW = 3'h4;
  localparam logic [5:0] RST_CONTACT_RW = 6'h08;
  localparam logic [7:0] RST_SYS_RESET_CTRL = 8'h00;
  localparam logic [7:0] RST_ADAPTER_REQ = 8'h00;
  localparam logic [7:0] RST_IR_COMP_CTRL = 8'h40;
  localparam logic [2:0] RST_BOOST_RSV = 3'h0;
  localparam int SYS_RESET_DIS_BIT = 7;
  localparam int ADP_ENABLE_BIT = 7;
  localparam int ADP_SCHEME_BIT = 6;
  localparam int ADP_DIR_BIT = 5;
  localparam int IR_RES_LSB = 3;
  localparam int IR_CLAMP_LSB = 0;
  localparam int BOOST_RSV_LSB = 2;
  // read-to-clear bits that really latch events
  localparam logic [7:0] CHARGE_EVENT_BITS = 8'hfb;
  localparam logic [7:0] BOOST_EVENT_BITS = 8'he3;

  // ********************************
  // adapter request and compensation scaling
  // ********************************
  localparam logic [15:0] ADP_BASE_MV = 16'h157c;
  localparam logic [15:0] ADP_STEP_MV = 16'h01f4;
  localparam logic [4:0] ADP_CODE_MAX = 5'h12;
  localparam logic [4:0] ADP_CODE_SELF_TEST = 5'h1e;
  localparam logic [4:0] ADP_CODE_CABLE_OFF = 5'h1f;
  localparam logic [7:0] IR_RES_STEP_MOHM = 8'h19;
  localparam logic [7:0] IR_CLAMP_STEP_MV = 8'h20;

  // ********************************
  // encodings
  // ********************************
  typedef enum logic [2:0] {
    CSER_USB_NONE = 3'b000, CSER_USB_BUSY = 3'b001, CSER_USB_SDP = 3'b010,
    CSER_USB_SDP_NSTD = 3'b011, CSER_USB_DCP = 3'b100, CSER_USB_CDP = 3'b101
  } cser_usb_t;
  typedef enum logic [1:0] {
    CSER_CHG_READY = 2'b00, CSER_CHG_ACTIVE = 2'b01, CSER_CHG_DONE = 2'b10,
    CSER_PROTECTION_STATUS = 2'b11
  } cser_chg_t;
  typedef enum logic [2:0] {
    CSER_NTC_NORMAL = 3'b000, CSER_NTC_WARM = 3'b010, CSER_NTC_COOL = 3'b011,
    CSER_NTC_COLD = 3'b101, CSER_NTC_HOT = 3'b110
  } cser_ntc_t;

endpackage : cser_pkg

/* File: logic/cser_regs.sv */
// Functional notes
// RULE1: port type field reports none, busy, standard, nonstandard, dedicated, charging-downstream.
// RULE2: dedicated, charging-downstream and standard port flags at bits 2..0, reset zero.
// RULE3: bit 1 reads one once data contact timeout expired.
// RULE4: bit 0 reads one when dedicated or charging-downstream port found.
// RULE5: system reset stays enabled while control bit 7 is zero.
// RULE6: adapter pulses pass only while enabled; scheme and direction bits alongside.
// RULE7: voltage code maps 5.5 V upward by 0.5 V; top codes special.
// RULE8: IR compensation resistance 0..175 milliohm, 25 milliohm steps, reset zero.
// RULE9: IR compensation clamp 0..224 mV, 32 mV steps, reset zero.
// RULE10: identification byte holds vendor nibble high, revision nibble low.
// RULE11: two-bit charger state: ready, charging, done, fault.
// RULE12: bit 5 fast-charge level, bit 4 trickle level.
// RULE13: bit 3 boost mode, bit 2 boost bus overvoltage.
// RULE14: status bit 0 reads one while ADC converts.
// RULE15: three-bit thermistor zone: normal, warm, cool, cold, hot.
// RULE16: ADC result as high and low byte registers, reset zero; the block reads ADC_RESULT straight through, with no reset.
// RULE17: power-good bit reflects input inside its valid window.
// RULE18: bits 6..4 show input voltage, input current and thermal loops active.
// RULE19: bus, battery, system overvoltage and system undervoltage live at bits 7..4.
// RULE20: battery hot, warm, cool, cold at bits 7..4, zero when normal.
// RULE21: fault flags latch, plus one flag per status register change.
// RULE22: charge progress flags latch until read.
// RULE23: boost flags latch until read; reserved bits 4..2 writable.
// RULE24: a flag with its mask bit set raises no interrupt.
// RULE25: an event in the same cycle as its read keeps the flag set.
`timescale 1ns/1ps

module cser_regs #(
  parameter logic [3:0] VENDOR_CODE = 4'h3,  // arbitrary value
  parameter logic [3:0] SILICON_REVISION = 4'h1  // arbitrary value
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic [2:0] USB_PORT_TYPE,
  input wire logic STANDARD_CHARGING_PORT_FLAG,
  input wire logic CDP_FLAG,
  input wire logic SDP_FLAG,
  input wire logic CONTACT_TIMEOUT_FLAG,
  input wire logic [1:0] CHARGER_STATE_CODE,
  input wire logic FAST_LEVEL_FLAG,
  input wire logic TRICKLE_LEVEL_FLAG,
  input wire logic BOOST_MODE_FLAG,
  input wire logic BOOST_BUS_OVERVOLT,
  input wire logic [2:0] THERMISTOR_ZONE_CODE,
  input wire logic [3:0] LOOP_STATUS,
  input wire logic [3:0] PROTECTION_STATUS,
  input wire logic [3:0] TEMP_STATUS,
  input wire logic ADC_BUSY,
  input wire logic [15:0] ADC_RESULT,
  input wire logic [4:0] FAULT_EVENTS,
  input wire logic [7:0] CHARGE_EVENTS,
  input wire logic [7:0] BOOST_EVENTS,
  input wire logic [7:0] FAULT_MASK,
  input wire logic [7:0] CHARGE_MASK,
  input wire logic [7:0] BOOST_MASK,
  input wire logic ADAPTER_PULSE_REQ,
  output logic EVENT_PENDING,
  output logic SYS_RESET_ENABLE,
  output logic ADAPTER_PULSE,
  output logic ADAPTER_SCHEME_SELECT,
  output logic ADAPTER_STEP_DIRECTION,
  output logic [15:0] ADAPTER_TARGET_MV,
  output logic ADAPTER_SELF_TEST,
  output logic CABLE_COMP_DISABLE,
  output logic ADAPTER_CODE_RESERVED,
  output logic [7:0] IR_COMP_MOHM,
  output logic [7:0] IR_COMP_CLAMP_MV
);

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic [27:0] sync1;
    logic [27:0] sync2;
    logic [11:0] prev_stat;
    logic [2:0] usb_rw;
    logic [5:0] contact_rw;
    logic [7:0] sys_reset_ctrl;
    logic [7:0] adapter_req;
    logic [7:0] ir_comp_ctrl;
    logic [2:0] boost_rsv;
    logic [7:0] fault_ev;
    logic [7:0] charge_ev;
    logic [7:0] boost_ev;
    logic [7:0] rdata;
    logic pending;
    logic rst_en;
    logic pulse;
    logic [15:0] target_mv;
    logic self_test;
    logic cable_off;
    logic code_rsv;
    logic [7:0] ir_mohm;
    logic [7:0] ir_mv;
  } cser_state_t;

  cser_state_t s_q;
  cser_state_t s_d;

  // pin-level status from analog comparators, not on this clock
  logic [27:0] async_in;
  assign async_in = {USB_PORT_TYPE, STANDARD_CHARGING_PORT_FLAG, CDP_FLAG, SDP_FLAG,
                     CONTACT_TIMEOUT_FLAG, CHARGER_STATE_CODE, FAST_LEVEL_FLAG,
                     TRICKLE_LEVEL_FLAG, BOOST_MODE_FLAG, BOOST_BUS_OVERVOLT,
                     THERMISTOR_ZONE_CODE, LOOP_STATUS, PROTECTION_STATUS, TEMP_STATUS};

  // synchronised views
  logic [2:0] usb_type;
  logic dcp;
  logic cdp;
  logic sdp;
  logic dcd_timeout;
  logic [1:0] chg_state;
  logic fast_lvl;
  logic trickle_lvl;
  logic boost_mode;
  logic boost_ovp;
  logic [2:0] ntc_zone;
  logic [3:0] loop_stat;
  logic [3:0] prot_stat;
  logic [3:0] temp_stat;
  assign usb_type = s_q.sync2[27:25];
  assign dcp = s_q.sync2[24];
  assign cdp = s_q.sync2[23];
  assign sdp = s_q.sync2[22];
  assign dcd_timeout = s_q.sync2[21];
  assign chg_state = s_q.sync2[20:19];
  assign fast_lvl = s_q.sync2[18];
  assign trickle_lvl = s_q.sync2[17];
  assign boost_mode = s_q.sync2[16];
  assign boost_ovp = s_q.sync2[15];
  assign ntc_zone = s_q.sync2[14:12];
  assign loop_stat = s_q.sync2[11:8];
  assign prot_stat = s_q.sync2[7:4];
  assign temp_stat = s_q.sync2[3:0];

  logic loop_changed;
  logic prot_changed;
  logic temp_changed;
  assign loop_changed = loop_stat != s_q.prev_stat[11:8];
  assign prot_changed = prot_stat != s_q.prev_stat[7:4];
  assign temp_changed = temp_stat != s_q.prev_stat[3:0];

  logic wr_hit;
  logic rd_hit;
  assign wr_hit = REG_WR;
  assign rd_hit = REG_RD;

  // ********************************
  // next state
  // ********************************
  always_comb begin
    logic [7:0] rd_val;
    logic [7:0] fault_new;
    logic [7:0] charge_new;
    logic [7:0] boost_new;
    logic [4:0] code;
    rd_val = 8'h00;
    fault_new = 8'h00;
    charge_new = 8'h00;
    boost_new = 8'h00;
    code = 5'h00;
    s_d = s_q;
    s_d.sync1 = async_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev_stat = {loop_stat, prot_stat, temp_stat};

    // readback of the block's own view
    case (REG_ADDR)
      cser_pkg::OFS_PORT_DETECT: rd_val = {5'h00, dcp, cdp, sdp};  // see RULE2
      cser_pkg::OFS_USB_PORT_TYPE: rd_val = {s_q.usb_rw, 2'h0, usb_type};  // see RULE1
      cser_pkg::OFS_CONTACT_DETECT: begin
        rd_val = {s_q.contact_rw, dcd_timeout, dcp | cdp};  // see RULE3 see RULE4
      end
      cser_pkg::OFS_SYS_RESET_CTRL: rd_val = s_q.sys_reset_ctrl;
      cser_pkg::OFS_ADAPTER_REQ: rd_val = s_q.adapter_req;
      cser_pkg::OFS_IR_COMP_CTRL: rd_val = s_q.ir_comp_ctrl;
      cser_pkg::OFS_IDENT: rd_val = {VENDOR_CODE, SILICON_REVISION};  // see RULE10
      cser_pkg::OFS_CHARGER_STATE: begin
        // see RULE11 see RULE12 see RULE13 see RULE14
        rd_val = {chg_state, fast_lvl, trickle_lvl, boost_mode, boost_ovp, 1'b0, ADC_BUSY};
      end
      cser_pkg::OFS_THERM_ZONE: rd_val = {1'b0, ntc_zone, 4'h0};  // see RULE15
      cser_pkg::OFS_ADC_HIGH: rd_val = ADC_RESULT[15:8];  // see RULE16
      cser_pkg::OFS_ADC_LOW: rd_val = ADC_RESULT[7:0];  // see RULE16
      cser_pkg::OFS_LOOP_STATUS: rd_val = {loop_stat, 4'h0};  // see RULE17 see RULE18
      cser_pkg::OFS_PROTECT_STATUS: rd_val = {prot_stat, 4'h0};  // see RULE19
      cser_pkg::OFS_TEMP_STATUS: rd_val = {temp_stat, 4'h0};  // see RULE20
      cser_pkg::OFS_FAULT_EVENTS: rd_val = s_q.fault_ev;
      cser_pkg::OFS_CHARGE_EVENTS: rd_val = s_q.charge_ev;
      cser_pkg::OFS_BOOST_EVENTS: begin
        rd_val = {s_q.boost_ev[7:5], s_q.boost_rsv, s_q.boost_ev[1:0]};
      end
      default: rd_val = 8'h00;
    endcase
    s_d.rdata = rd_hit ? rd_val : s_q.rdata;

    // writes; read-only bits simply ignore the data
    if (wr_hit) begin
      case (REG_ADDR)
        cser_pkg::OFS_USB_PORT_TYPE: s_d.usb_rw = REG_WDATA[7:5];
        cser_pkg::OFS_CONTACT_DETECT: s_d.contact_rw = REG_WDATA[7:2];
        cser_pkg::OFS_SYS_RESET_CTRL: s_d.sys_reset_ctrl = REG_WDATA;
        cser_pkg::OFS_ADAPTER_REQ: s_d.adapter_req = REG_WDATA;
        cser_pkg::OFS_IR_COMP_CTRL: s_d.ir_comp_ctrl = REG_WDATA;
        cser_pkg::OFS_BOOST_EVENTS: begin
          s_d.boost_rsv = REG_WDATA[cser_pkg::BOOST_RSV_LSB +: 3];  // see RULE23
        end
        default: s_d.usb_rw = s_q.usb_rw;
      endcase
    end

    // sticky flags: a new event wins over the read that clears
    fault_new = {FAULT_EVENTS, loop_changed, prot_changed, temp_changed};  // see RULE21
    charge_new = CHARGE_EVENTS & cser_pkg::CHARGE_EVENT_BITS;  // see RULE22
    boost_new = BOOST_EVENTS & cser_pkg::BOOST_EVENT_BITS;  // see RULE23
    s_d.fault_ev = ((rd_hit && REG_ADDR == cser_pkg::OFS_FAULT_EVENTS) ? 8'h00
                    : s_q.fault_ev) | fault_new;  // see RULE25
    s_d.charge_ev = ((rd_hit && REG_ADDR == cser_pkg::OFS_CHARGE_EVENTS) ? 8'h00
                     : s_q.charge_ev) | charge_new;  // see RULE25
    s_d.boost_ev = ((rd_hit && REG_ADDR == cser_pkg::OFS_BOOST_EVENTS) ? 8'h00
                    : s_q.boost_ev) | boost_new;  // see RULE25
    s_d.pending = |(s_d.fault_ev & ~FAULT_MASK) | |(s_d.charge_ev & ~CHARGE_MASK)
                  | |(s_d.boost_ev & ~BOOST_MASK);  // see RULE24

    // controls follow the registers one cycle later
    s_d.rst_en = ~s_q.sys_reset_ctrl[cser_pkg::SYS_RESET_DIS_BIT];  // see RULE5
    s_d.pulse = ADAPTER_PULSE_REQ & s_q.adapter_req[cser_pkg::ADP_ENABLE_BIT];  // see RULE6
    code = s_q.adapter_req[4:0];
    s_d.self_test = code == cser_pkg::ADP_CODE_SELF_TEST;  // see RULE7
    s_d.cable_off = code == cser_pkg::ADP_CODE_CABLE_OFF;  // see RULE7
    s_d.code_rsv = code > cser_pkg::ADP_CODE_MAX && code < cser_pkg::ADP_CODE_SELF_TEST;
    // reserved and special codes carry no voltage target
    s_d.target_mv = (code <= cser_pkg::ADP_CODE_MAX)
                    ? 16'(cser_pkg::ADP_BASE_MV + 16'(code) * cser_pkg::ADP_STEP_MV)
                    : 16'h0000;  // see RULE7
    s_d.ir_mohm = 8'(8'(s_q.ir_comp_ctrl[cser_pkg::IR_RES_LSB +: 3])
                     * cser_pkg::IR_RES_STEP_MOHM);  // see RULE8
    s_d.ir_mv = 8'(8'(s_q.ir_comp_ctrl[cser_pkg::IR_CLAMP_LSB +: 3])
                   * cser_pkg::IR_CLAMP_STEP_MV);  // see RULE9
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s_q <= '0;
      s_q.usb_rw <= cser_pkg::RST_USB_RW;
      s_q.contact_rw <= cser_pkg::RST_CONTACT_RW;
      s_q.sys_reset_ctrl <= cser_pkg::RST_SYS_RESET_CTRL;
      s_q.adapter_req <= cser_pkg::RST_ADAPTER_REQ;
      s_q.ir_comp_ctrl <= cser_pkg::RST_IR_COMP_CTRL;
      s_q.boost_rsv <= cser_pkg::RST_BOOST_RSV;
      s_q.rst_en <= 1'b1;
      s_q.target_mv <= cser_pkg::ADP_BASE_MV;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign REG_RDATA = s_q.rdata;
  assign EVENT_PENDING = s_q.pending;
  assign SYS_RESET_ENABLE = s_q.rst_en;
  assign ADAPTER_PULSE = s_q.pulse;
  assign ADAPTER_SCHEME_SELECT = s_q.adapter_req[cser_pkg::ADP_SCHEME_BIT];
  assign ADAPTER_STEP_DIRECTION = s_q.adapter_req[cser_pkg::ADP_DIR_BIT];
  assign ADAPTER_TARGET_MV = s_q.target_mv;
  assign ADAPTER_SELF_TEST = s_q.self_test;
  assign CABLE_COMP_DISABLE = s_q.cable_off;
  assign ADAPTER_CODE_RESERVED = s_q.code_rsv;
  assign IR_COMP_MOHM = s_q.ir_mohm;
  assign IR_COMP_CLAMP_MV = s_q.ir_mv;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_write_sysrst_dis;
    REG_WR && REG_ADDR == cser_pkg::OFS_SYS_RESET_CTRL && REG_WDATA[7];
  endsequence
  sequence s_loop_move;
    loop_changed;
  endsequence

  AST_SYS_RESET_OFF: assert property (s_write_sysrst_dis |-> ##2 !SYS_RESET_ENABLE) // see RULE5
    else $error("system reset still enabled after disable write");
  AST_PULSE_GATED: assert property (
    ADAPTER_PULSE_REQ && !s_q.adapter_req[7] |=> !ADAPTER_PULSE) // see RULE6
    else $error("adapter pulse while disabled");
  AST_SELF_TEST_CODE: assert property (
    s_q.adapter_req[4:0] == 5'h1e |=> ADAPTER_SELF_TEST && ADAPTER_TARGET_MV == 16'h0000) // see RULE7
    else $error("self-test code not decoded");
  AST_IR_RES: assert property (
    ##1 IR_COMP_MOHM == 8'(8'($past(s_q.ir_comp_ctrl[5:3])) * 8'h19)) // see RULE8
    else $error("IR resistance scaling wrong");
  AST_IR_CLAMP: assert property (
    ##1 IR_COMP_CLAMP_MV == 8'(8'($past(s_q.ir_comp_ctrl[2:0])) * 8'h20)) // see RULE9
    else $error("IR clamp scaling wrong");
  AST_PORT_FOUND: assert property (
    REG_RD && REG_ADDR == 8'h14 |=> REG_RDATA[0] == $past(dcp | cdp)) // see RULE4
    else $error("charging port found bit wrong");
  AST_USB_TYPE: assert property (
    REG_RD && REG_ADDR == 8'h13 |=> REG_RDATA[2:0] == $past(usb_type)) // see RULE1
    else $error("port type field wrong");
  AST_LOOP_CHANGE: assert property (s_loop_move |=> s_q.fault_ev[2]) // see RULE21
    else $error("loop status change not latched");
  AST_KEEP_ON_READ: assert property (
    REG_RD && REG_ADDR == 8'h53 && FAULT_EVENTS[4] |=> s_q.fault_ev[7]) // see RULE25
    else $error("event lost under read clear");
  AST_READ_CLEARS: assert property (
    REG_RD && REG_ADDR == 8'h54 && CHARGE_EVENTS == 8'h00 |=> s_q.charge_ev == 8'h00) // see RULE22
    else $error("charge flags not cleared by read");
  AST_BOOST_RSV: assert property (
    REG_WR && REG_ADDR == 8'h55 |=> s_q.boost_rsv == $past(REG_WDATA[4:2])) // see RULE23
    else $error("boost reserved bits not written");
  AST_MASKED_QUIET: assert property (
    FAULT_MASK == 8'hff && CHARGE_MASK == 8'hff && BOOST_MASK == 8'hff
    |=> !EVENT_PENDING) // see RULE24
    else $error("masked flag raised pending");

endmodule : cser_regs

/* File: test/cser_host_model.sv */
`timescale 1ns/1ps

module cser_host_model (
  input wire logic CLK_SYS,
  input wire logic [7:0] REG_RDATA,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD
);
  // ********************************
  // one strobe cycle per access
  // ********************************
  initial begin
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK_SYS);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLK_SYS);
    REG_WR = 1'b0;
    REG_ADDR = ~a;
    REG_WDATA = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK_SYS);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLK_SYS);
    REG_RD = 1'b0;
    REG_ADDR = ~a;
    d = REG_RDATA;
  endtask : rd
endmodule : cser_host_model

/* File: test/cser_regs_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module cser_regs_test;
  logic clk_sys, rst, reg_wr, reg_rd, std_f, cdp_f, sdp_f, cto, fast, trk, bst, bov;
  logic adc_busy, preq, evp, sre, apulse, ascheme, adir, atest, cdis, ares;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cev, bev, fmask, cmask, bmask, irm, irc, r;
  logic [7:0] rc, rb;
  logic [2:0] usb, zone, chg;
  logic [1:0] cst;
  logic [3:0] loop_s, prot_s, temp_s, pl, pp, pt;
  logic [15:0] adc, amv;
  logic [4:0] fev;
  logic [2:0] zones [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  cser_regs cser_regs_inst (.CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .USB_PORT_TYPE(usb), .STANDARD_CHARGING_PORT_FLAG(std_f), .CDP_FLAG(cdp_f),
    .SDP_FLAG(sdp_f), .CONTACT_TIMEOUT_FLAG(cto), .CHARGER_STATE_CODE(cst),
    .FAST_LEVEL_FLAG(fast), .TRICKLE_LEVEL_FLAG(trk), .BOOST_MODE_FLAG(bst),
    .BOOST_BUS_OVERVOLT(bov), .THERMISTOR_ZONE_CODE(zone), .LOOP_STATUS(loop_s),
    .PROTECTION_STATUS(prot_s), .TEMP_STATUS(temp_s), .ADC_BUSY(adc_busy),
    .ADC_RESULT(adc), .FAULT_EVENTS(fev), .CHARGE_EVENTS(cev), .BOOST_EVENTS(bev),
    .FAULT_MASK(fmask), .CHARGE_MASK(cmask), .BOOST_MASK(bmask),
    .ADAPTER_PULSE_REQ(preq), .EVENT_PENDING(evp), .SYS_RESET_ENABLE(sre),
    .ADAPTER_PULSE(apulse), .ADAPTER_SCHEME_SELECT(ascheme),
    .ADAPTER_STEP_DIRECTION(adir), .ADAPTER_TARGET_MV(amv), .ADAPTER_SELF_TEST(atest),
    .CABLE_COMP_DISABLE(cdis), .ADAPTER_CODE_RESERVED(ares), .IR_COMP_MOHM(irm),
    .IR_COMP_CLAMP_MV(irc));

  cser_host_model cser_host_model_inst (.CLK_SYS(clk_sys), .REG_RDATA(reg_rdata),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd));

  always #10 clk_sys = ~clk_sys;

  task automatic results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // generous ceiling, the run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    cser_host_model_inst.rd(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask : rdc

  task automatic ev_pulse(input logic [4:0] f);
    @(negedge clk_sys);
    fev = f;
    @(negedge clk_sys);
    fev = 5'h00;
  endtask : ev_pulse

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {usb, zone, std_f, cdp_f, sdp_f, cto, cst, fast, trk, bst, bov} = '0;
    {loop_s, prot_s, temp_s, pl, pp, pt, adc_busy, adc, fev, cev, bev, preq} = '0;
    {fmask, cmask, bmask} = 24'hffffff;
    void'($urandom(64177));
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    // ********************************
    // reset state
    // ********************************
    `CHK("sys_reset_enable", 1'b1, sre)
    `CHK("target_mv", 16'h157c, amv)
    `CHK("pending", 1'b0, evp)
    rdc(8'h13, 8'h80);
    rdc(8'h14, 8'h20);
    rdc(8'h18, 8'h00);
    rdc(8'h19, 8'h00);
    rdc(8'h1a, 8'h40);
    rdc(8'h40, 8'h31);
    rdc(8'h41, 8'h00);
    cser_host_model_inst.wr(8'h40, 8'hff);
    rdc(8'h40, 8'h31);
    // ********************************
    // live status through the synchronisers
    // ********************************
    repeat (8) begin
      @(negedge clk_sys);
      usb = 3'($urandom_range(5));
      {std_f, cdp_f, sdp_f, cto, fast, trk, bst, bov, adc_busy} = 9'($urandom);
      cst = 2'($urandom);
      zone = zones[$urandom_range(4)];
      {loop_s, prot_s, temp_s} = 12'($urandom);
      adc = 16'($urandom);
      fmask = 8'($urandom);
      repeat (4) @(negedge clk_sys);
      rdc(8'h12, {5'h00, std_f, cdp_f, sdp_f});
      rdc(8'h13, {3'h4, 2'h0, usb});
      rdc(8'h14, {6'h08, cto, std_f | cdp_f});
      rdc(8'h42, {cst, fast, trk, bst, bov, 1'b0, adc_busy});
      rdc(8'h43, {1'b0, zone, 4'h0});
      rdc(8'h44, adc[15:8]);
      rdc(8'h45, adc[7:0]);
      rdc(8'h50, {loop_s, 4'h0});
      rdc(8'h51, {prot_s, 4'h0});
      rdc(8'h52, {temp_s, 4'h0});
      chg = {loop_s != pl, prot_s != pp, temp_s != pt};
      `CHK("pending", |(chg & ~fmask[2:0]), evp)
      rdc(8'h53, {5'h00, chg});
      {pl, pp, pt} = {loop_s, prot_s, temp_s};
    end
    // ********************************
    // control registers and decodes
    // ********************************
    for (int c = 0; c < 32; c++) begin
      r = {3'($urandom), 5'(c)};
      cser_host_model_inst.wr(8'h19, r);
      @(negedge clk_sys);
      `CHK("target_mv", c <= 18 ? 16'h157c + 16'(c) * 16'h01f4 : 16'h0000, amv)
      `CHK("flags", {c == 30, c == 31, c >= 19 && c <= 29}, {atest, cdis, ares})
      `CHK("scheme_dir", r[6:5], {ascheme, adir})
      rdc(8'h19, r);
      @(negedge clk_sys);
      preq = 1'b1;
      @(negedge clk_sys);
      preq = 1'b0;
      `CHK("pulse", r[7], apulse)
    end
    repeat (8) begin
      r = 8'($urandom);
      cser_host_model_inst.wr(8'h1a, r);
      cser_host_model_inst.wr(8'h18, r);
      // reset enable follows the register one edge after the write lands
      @(negedge clk_sys);
      `CHK("ir_mohm", 8'(r[5:3]) * 8'h19, irm)
      `CHK("ir_clamp", 8'(r[2:0]) * 8'h20, irc)
      `CHK("sys_reset_enable", ~r[7], sre)
      rdc(8'h1a, r);
      rdc(8'h18, r);
    end
    // ********************************
    // read-to-clear event flags
    // ********************************
    cser_host_model_inst.wr(8'h55, 8'h1c);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      fev = 5'($urandom);
      cev = 8'($urandom);
      bev = 8'($urandom);
      {fmask, cmask, bmask} = i == 0 ? 24'hffffff : 24'($urandom);
      r = {fev, 3'h0};
      rc = cev & 8'hfb;
      rb = bev & 8'he3;
      @(negedge clk_sys);
      {fev, cev, bev} = '0;
      `CHK("pending", |(r & ~fmask) | |(rc & ~cmask) | |(rb & ~bmask), evp)
      rdc(8'h53, r);
      rdc(8'h54, rc);
      rdc(8'h55, rb | 8'h1c);
      rdc(8'h53, 8'h00);
      `CHK("pending", 1'b0, evp)
    end
    // a new event in the clearing read keeps the flag
    ev_pulse(5'h10);
    fork
      rdc(8'h53, 8'h80);
      ev_pulse(5'h10);
    join
    rdc(8'h53, 8'h80);
    rdc(8'h53, 8'h00);
    results();
  end
endmodule : cser_regs_test
